// File: sbst_consts.svh
// constants of the boundary-scan test access port
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH
`define SBST_IR_LEN      3
`define SBST_ID_LEN      32
`define SBST_BSR_LEN     109
`define SBST_CELL_OE     108
`define SBST_IR_EXTEST   3'h0
`define SBST_IR_IDCODE   3'h1
`define SBST_IR_SAMPLEZ  3'h2
`define SBST_IR_SAMPLE   3'h4
`define SBST_IR_BYPASS   3'h7
`define SBST_IR_CAPTURE  3'h1
`define SBST_ID_REV_LSB  29
`define SBST_ID_DEV_LSB  12
`define SBST_ID_VEND_LSB 1
`define SBST_FIFO_DEPTH  4
`define SBST_DATA_W      36
`endif

// File: sbst_pkg.sv
// types shared by the boundary-scan test access port
`default_nettype none
package sbst_pkg;
   `include "sbst_consts.svh"
   typedef logic [`SBST_IR_LEN-1:0] sbst_ir_t;
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
      ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
   } sbst_tap_st_t;
   // word carried from the test clock side to the system side
   typedef struct packed {
      sbst_ir_t                  ir;
      logic [`SBST_BSR_LEN-1:0]  cells;
   } sbst_xfer_t;
   // test clock side state
   typedef struct packed {
      sbst_tap_st_t              st;
      sbst_ir_t                  ir_sh;
      sbst_ir_t                  ir;
      logic                      byp;
      logic [`SBST_ID_LEN-1:0]   id_sh;
      logic [`SBST_BSR_LEN-1:0]  bsr_sh;
      logic [`SBST_BSR_LEN-1:0]  bsr_upd;
      sbst_xfer_t                hold;
      logic                      tgl;
      logic                      tlr_sent;
   } sbst_tck_t;
endpackage : sbst_pkg
`default_nettype wire

// File: sbst_tap.sv
// boundary-scan test access port with read data output stage
// Notes on behaviour
// - instruction 3, bypass 1, id 32, boundary 109
// - code 000 captures ring cells into chain
// - code 001 loads id, memory unaffected
// - code 010 selects chain, floats memory outputs
// - code 100 captures ring, selects chain, harmless
// - code 111 selects bypass bit, memory unaffected
// - internal cell 108 gates outputs under extest
// - cell 108 preset high in test-logic-reset
// - id bit0 one, revision, device, vendor fields
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.svh"

// ----------------------------------------------------------------
// small fifo between core read data and the output stage
// ----------------------------------------------------------------
module sbst_fifo #(
   parameter int W = 36,
   parameter int D = 4
) (
   input  wire logic          clk_sys,
   input  wire logic          reset_n,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic [W-1:0]       out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
      logic                rdy;
   } sbst_fifo_st_t;
   sbst_fifo_st_t f_q, f_d;
   logic push, pop;

   // ready kept in a flop so the port needs no logic after the count
   assign in_ready  = f_q.rdy;
   assign out_valid = (f_q.cnt != '0);
   assign out_data  = f_q.mem[f_q.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer and count update; pointers wrap at the depth
   always_comb begin
      f_d = f_q;
      if (push) begin
         f_d.mem[f_q.wr] = in_data;
         f_d.wr = (f_q.wr == AW'(D-1)) ? '0 : AW'(f_q.wr + 1'b1);
      end
      if (pop) begin
         f_d.rd = (f_q.rd == AW'(D-1)) ? '0 : AW'(f_q.rd + 1'b1);
      end
      f_d.cnt = (AW+1)'(f_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      f_d.rdy = (f_d.cnt != (AW+1)'(D));
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         f_q     <= '0;
         f_q.rdy <= 1'b1;
      end else begin
         f_q <= f_d;
      end
   end

   property p_cnt_max;
      @(posedge clk_sys) disable iff (!reset_n) f_q.cnt <= (AW+1)'(D);
   endproperty
   a_cnt_max: assert property (p_cnt_max) else $error("fifo count above depth");
   c_full: cover property (@(posedge clk_sys) disable iff (!reset_n) !in_ready);
endmodule : sbst_fifo

// ----------------------------------------------------------------
// top: tap on the test clock, output control on the system clock
// ----------------------------------------------------------------
module sbst_tap
   import sbst_pkg::*;
#(
   parameter int                   DATA_W  = `SBST_DATA_W,
   parameter logic [2:0]           ID_REV  = 3'h0,      // value arbitrary
   parameter logic [16:0]          ID_DEV  = 17'h0_0a5a, // value arbitrary
   parameter logic [10:0]          ID_VEND = 11'h155     // value arbitrary
) (
   input  wire logic                       clk_sys,
   input  wire logic                       reset_n,
   input  wire logic                       tck,
   input  wire logic                       tms,
   input  wire logic                       tdi,
   output logic                            tdo,
   output logic                            tdo_oe,
   input  wire logic [`SBST_BSR_LEN-2:0]   ring_in,
   output logic [`SBST_BSR_LEN-2:0]        ring_out,
   output logic                            ring_drive,
   input  wire logic                       rd_valid,
   output logic                            rd_ready,
   input  wire logic [DATA_W-1:0]          rd_data,
   output logic                            q_valid,
   input  wire logic                       q_ready,
   output logic [DATA_W-1:0]               q_data,
   output logic                            q_oe
);
   import sbst_pkg::*;

   localparam logic [`SBST_ID_LEN-1:0] ID_VAL = {ID_REV, ID_DEV, ID_VEND, 1'b1};

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic sbst_is_bsr(input sbst_ir_t ir);
      return (ir == `SBST_IR_EXTEST) || (ir == `SBST_IR_SAMPLEZ) || (ir == `SBST_IR_SAMPLE);
   endfunction : sbst_is_bsr

   // unknown codes fall back to the bypass bit so the chain length stays sane
   function automatic logic sbst_is_byp(input sbst_ir_t ir);
      return !sbst_is_bsr(ir) && (ir != `SBST_IR_IDCODE);
   endfunction : sbst_is_byp

   function automatic sbst_tap_st_t sbst_next(input sbst_tap_st_t s, input logic m);
      unique case (s)
         ST_TLR:    return m ? ST_TLR    : ST_RTI;
         ST_RTI:    return m ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: return m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: return m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  return m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: return m ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  return m ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: return m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: return m ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: return m ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: return m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  return m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: return m ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  return m ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: return m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: return m ? ST_SEL_DR : ST_RTI;
      endcase
   endfunction : sbst_next

   // ----------------------------------------------------------------
   // test clock domain: reset and ring pin synchronisers
   // ----------------------------------------------------------------
   logic                      trst_m, trst_s;
   logic [`SBST_BSR_LEN-2:0]  ring_m, ring_s;
   sbst_tck_t                 t_q, t_d;
   logic                      send;

   // two stages each; only the second stage is read by logic
   always_ff @(posedge tck) begin
      trst_m <= reset_n;
      trst_s <= trst_m;
      ring_m <= ring_in;
      ring_s <= ring_m;
   end

   // controller, instruction and data registers
   always_comb begin
      t_d  = t_q;
      send = 1'b0;
      t_d.st = sbst_next(t_q.st, tms);
      if (t_q.st != ST_TLR) begin
         t_d.tlr_sent = 1'b0;
      end
      unique case (t_q.st)
         ST_TLR: begin
            t_d.ir = `SBST_IR_IDCODE;
            t_d.bsr_upd[`SBST_CELL_OE] = 1'b1;
            send = !t_q.tlr_sent;
            t_d.tlr_sent = 1'b1;
         end
         ST_CAP_IR: t_d.ir_sh = `SBST_IR_CAPTURE;
         ST_SH_IR:  t_d.ir_sh = {tdi, t_q.ir_sh[`SBST_IR_LEN-1:1]};
         ST_UPD_IR: begin
            t_d.ir = t_q.ir_sh;
            send = 1'b1;
         end
         ST_CAP_DR: begin
            if (sbst_is_bsr(t_q.ir)) begin
               // internal cell reports its own latched value, it has no pin
               t_d.bsr_sh = {t_q.bsr_upd[`SBST_CELL_OE], ring_s};
            end else if (t_q.ir == `SBST_IR_IDCODE) begin
               t_d.id_sh = ID_VAL;
            end else begin
               t_d.byp = 1'b0;
            end
         end
         ST_SH_DR: begin
            if (sbst_is_bsr(t_q.ir)) begin
               t_d.bsr_sh = {tdi, t_q.bsr_sh[`SBST_BSR_LEN-1:1]};
            end else if (t_q.ir == `SBST_IR_IDCODE) begin
               t_d.id_sh = {tdi, t_q.id_sh[`SBST_ID_LEN-1:1]};
            end else begin
               t_d.byp = tdi;
            end
         end
         ST_UPD_DR: begin
            if (sbst_is_bsr(t_q.ir)) begin
               t_d.bsr_upd = t_q.bsr_sh;
               send = 1'b1;
            end
         end
         default: ;
      endcase
      // hand the new mode and cells over; hold stays put until the next send
      if (send) begin
         t_d.hold.ir    = t_d.ir;
         t_d.hold.cells = t_d.bsr_upd;
         t_d.tgl        = !t_q.tgl;
      end
   end

   always_ff @(posedge tck) begin
      if (!trst_s) begin
         t_q <= '0;
         t_q.st <= ST_TLR;
         t_q.ir <= `SBST_IR_IDCODE;
         t_q.bsr_upd[`SBST_CELL_OE] <= 1'b1;
         t_q.hold.ir <= `SBST_IR_IDCODE;
         t_q.hold.cells[`SBST_CELL_OE] <= 1'b1;
      end else begin
         t_q <= t_d;
      end
   end

   // serial output launched on the falling edge, driven only while shifting
   always_ff @(negedge tck) begin
      if (!trst_s) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         tdo_oe <= (t_q.st == ST_SH_DR) || (t_q.st == ST_SH_IR);
         if (t_q.st == ST_SH_IR) begin
            tdo <= t_q.ir_sh[0];
         end else if (sbst_is_bsr(t_q.ir)) begin
            tdo <= t_q.bsr_sh[0];
         end else if (t_q.ir == `SBST_IR_IDCODE) begin
            tdo <= t_q.id_sh[0];
         end else begin
            tdo <= t_q.byp;
         end
      end
   end

   // ----------------------------------------------------------------
   // system clock domain: mode crossing and output control
   // ----------------------------------------------------------------
   logic        tgl_m, tgl_s, tgl_seen_q;
   sbst_xfer_t  mode_q;
   logic        q_float;
   logic        f_valid, f_pop;
   logic [DATA_W-1:0] f_data;

   // toggle synchroniser; the held word is stable long before it is read
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tgl_m <= 1'b0;
         tgl_s <= 1'b0;
      end else begin
         tgl_m <= t_q.tgl;
         tgl_s <= tgl_m;
      end
   end

   // output stage can stall on q_ready or while the bus floats
   assign q_float = !q_oe;
   assign f_pop   = f_valid && (!q_valid || (q_ready && !q_float));

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tgl_seen_q <= 1'b0;
         mode_q <= '0;
         mode_q.ir <= `SBST_IR_IDCODE;
         mode_q.cells[`SBST_CELL_OE] <= 1'b1;
         q_oe       <= 1'b1;
         ring_drive <= 1'b0;
         ring_out   <= '0;
         q_valid    <= 1'b0;
         q_data     <= '0;
      end else begin
         if (tgl_s != tgl_seen_q) begin
            tgl_seen_q <= tgl_s;
            mode_q     <= t_q.hold;
         end
         // high-z under sample-z, or under extest with the control cell low
         q_oe <= !((mode_q.ir == `SBST_IR_SAMPLEZ) ||
                   ((mode_q.ir == `SBST_IR_EXTEST) &&
                    !mode_q.cells[`SBST_CELL_OE]));
         ring_drive <= (mode_q.ir == `SBST_IR_EXTEST);
         ring_out   <= mode_q.cells[`SBST_BSR_LEN-2:0];
         if (f_pop) begin
            q_valid <= 1'b1;
            q_data  <= f_data;
         end else if (q_ready && !q_float) begin
            q_valid <= 1'b0;
         end
      end
   end

   sbst_fifo #(
      .W (DATA_W),
      .D (`SBST_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (rd_valid),
      .in_ready  (rd_ready),
      .in_data   (rd_data),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_tlr_five;
      @(posedge tck) disable iff (!trst_s) tms [*5] |=> (t_q.st == ST_TLR);
   endproperty
   a_tlr_five: assert property (p_tlr_five) else $error("no reset after 5 tms");

   property p_tlr_ir;
      @(posedge tck) disable iff (!trst_s) (t_q.st == ST_TLR) |=> (t_q.ir == `SBST_IR_IDCODE);
   endproperty
   a_tlr_ir: assert property (p_tlr_ir) else $error("ir not idcode after reset");

   property p_oe_preset;
      @(posedge tck) disable iff (!trst_s) (t_q.st == ST_TLR) |=> t_q.bsr_upd[`SBST_CELL_OE];
   endproperty
   a_oe_preset: assert property (p_oe_preset) else $error("control cell not preset");

   property p_id_cap;
      @(posedge tck) disable iff (!trst_s)
         (t_q.st == ST_CAP_DR) && (t_q.ir == `SBST_IR_IDCODE) |=> (t_q.id_sh == ID_VAL);
   endproperty
   a_id_cap: assert property (p_id_cap) else $error("id not loaded");

   property p_byp_cap;
      @(posedge tck) disable iff (!trst_s)
         (t_q.st == ST_CAP_DR) && (t_q.ir == `SBST_IR_BYPASS) |=> !t_q.byp;
   endproperty
   a_byp_cap: assert property (p_byp_cap) else $error("bypass not cleared");

   property p_bsr_shift;
      @(posedge tck) disable iff (!trst_s) (t_q.st == ST_SH_DR) && sbst_is_bsr(t_q.ir) |=>
         (t_q.bsr_sh[`SBST_BSR_LEN-2:0] == $past(t_q.bsr_sh[`SBST_BSR_LEN-1:1]));
   endproperty
   a_bsr_shift: assert property (p_bsr_shift) else $error("chain shift wrong");

   property p_ir_cap;
      @(posedge tck) disable iff (!trst_s)
         (t_q.st == ST_CAP_IR) |=> (t_q.ir_sh == `SBST_IR_CAPTURE) ##1 (t_q.ir == $past(t_q.ir, 2));
   endproperty
   a_ir_cap: assert property (p_ir_cap) else $error("ir capture wrong");

   property p_samplez_float;
      @(posedge clk_sys) disable iff (!reset_n) (mode_q.ir == `SBST_IR_SAMPLEZ) |=> !q_oe;
   endproperty
   a_samplez_float: assert property (p_samplez_float) else $error("sample-z drives");

   property p_extest_oe;
      @(posedge clk_sys) disable iff (!reset_n)
         (mode_q.ir == `SBST_IR_EXTEST) |=> (q_oe == $past(mode_q.cells[`SBST_CELL_OE]));
   endproperty
   a_extest_oe: assert property (p_extest_oe) else $error("cell does not gate q");

   property p_sample_drive;
      @(posedge clk_sys) disable iff (!reset_n)
         (mode_q.ir == `SBST_IR_SAMPLE) || (mode_q.ir == `SBST_IR_BYPASS) |=> q_oe && !ring_drive;
   endproperty
   a_sample_drive: assert property (p_sample_drive) else $error("memory disturbed");

   c_samplez: cover property (@(posedge clk_sys) disable iff (!reset_n) $fell(q_oe));
   c_id_shift: cover property (@(posedge tck) disable iff (!trst_s)
      (t_q.st == ST_SH_DR) && (t_q.ir == `SBST_IR_IDCODE));
   c_extest: cover property (@(posedge clk_sys) disable iff (!reset_n) $rose(ring_drive));
endmodule : sbst_tap
`default_nettype wire

// File: sbst_jtag_model.sv
// scan controller model that drives the test port of the scan block
`timescale 1ns/1ps
`default_nettype none

module sbst_jtag_model (
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   input  wire logic tdo
);
   // ---------------------------------------------------------------
   // test clock pulses only inside frames and stands low between them
   // ---------------------------------------------------------------
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one test clock: set up after the fall, sample tdo on the rise
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #80;
      tck = 1'b1;
      o   = tdo;   // launched on the previous fall
      #80;
      tck = 1'b0;
   endtask : tick

   // mode select held high walks any state to test-logic-reset
   task automatic idle_reset(input int n);
      logic o;
      for (int i = 0; i < n; i++) begin
         tick(1'b1, tdi, o);
      end
   endtask : idle_reset

   // from idle: capture, shift n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic o;
      dout = '0;
      tick(1'b1, tdi, o);
      if (ir) tick(1'b1, tdi, o);
      tick(1'b0, tdi, o);
      tick(1'b0, tdi, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], o);
         dout[i] = o;
      end
      // released data line shows the inverse, never a stale copy
      tick(1'b1, ~din[n-1], o);
      tick(1'b0, ~din[n-1], o);
   endtask : scan

   // instruction load; reserved codes are never sent, bypass instead
   task automatic load_ir(input logic [2:0] c, output logic [2:0] cap);
      logic [127:0] r;
      if (c inside {3'h3, 3'h5, 3'h6}) c = 3'h7;
      scan(1'b1, 3, 128'(c), r);
      cap = r[2:0];
   endtask : load_ir
endmodule : sbst_jtag_model

`default_nettype wire

// File: sbst_tap_tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.svh"

module sbst_tap_tb;
   import sbst_pkg::*;
   localparam logic [2:0]  TB_REV  = 3'h2;        // value arbitrary
   localparam logic [16:0] TB_DEV  = 17'h0_1234;  // value arbitrary
   localparam logic [10:0] TB_VEND = 11'h2a5;     // value arbitrary
   localparam logic [31:0] ID_EXP  = {TB_REV, TB_DEV, TB_VEND, 1'b1};
   localparam logic [35:0] WORD0   = 36'h1_2345_6700;
   logic        clk_sys, reset_n, tck, tms, tdi, tdo, tdo_oe, ring_drive;
   logic        rd_valid, rd_ready, q_valid, q_ready, q_oe, bit_o;
   logic [2:0]  cap;
   logic [107:0] ring_in, ring_out, pat;
   logic [35:0] rd_data, q_data;
   logic [127:0] so;
   int          failures, compares, n;

   sbst_tap #(.ID_REV(TB_REV), .ID_DEV(TB_DEV), .ID_VEND(TB_VEND)) i_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
      .ring_drive(ring_drive), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .q_valid(q_valid), .q_ready(q_ready), .q_data(q_data),
      .q_oe(q_oe));
   sbst_jtag_model i_ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   // ---------------------------------------------------------------
   // clock, compares and verdict
   // ---------------------------------------------------------------
   initial clk_sys = 1'b0;
   always #2.5 clk_sys = ~clk_sys;

   task automatic cmp_vec(input string nm, input logic [127:0] e, input logic [127:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : cmp_vec

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask : cmp_bit

   task automatic results();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // mode crossing lands well inside the idle clock after each update
   task automatic chk_mode(input logic oe, input logic drv);
      @(negedge clk_sys);
      cmp_bit("q_oe", oe, q_oe);
      cmp_bit("ring_drive", drv, ring_drive);
   endtask : chk_mode

   task automatic ir_load(input sbst_ir_t c);
      i_ctrl.load_ir(c, cap);
      cmp_vec("ir capture", 128'(`SBST_IR_CAPTURE), 128'(cap));
   endtask : ir_load

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_id();
      chk_mode(1'b1, 1'b0);
      cmp_bit("tdo_oe idle", 1'b0, tdo_oe);
      i_ctrl.scan(1'b0, 32, '0, so);
      cmp_vec("id word", 128'(ID_EXP), so);
      chk_mode(1'b1, 1'b0);
   endtask : t_reset_id

   // one-bit path: captured zero first, then data delayed by one clock
   task automatic t_bypass();
      ir_load(`SBST_IR_BYPASS);
      i_ctrl.scan(1'b0, 8, 128'h00a5, so);
      cmp_vec("bypass", 128'h004a, so);
      chk_mode(1'b1, 1'b0);
   endtask : t_bypass

   // fill while outputs float: four in the fifo plus one in the stage
   task automatic t_fill();
      n = 0;
      q_ready = 1'b1;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk_sys);
         rd_valid = rd_ready;
         rd_data  = WORD0 + 36'(n);
         if (rd_ready) n++;
      end
      @(negedge clk_sys);
      rd_valid = 1'b0;
      // stall the far side so nothing leaks out once the bus is enabled again
      q_ready  = 1'b0;
      cmp_vec("accepted words", 128'(5), 128'(n));
   endtask : t_fill

   // drain with the far side stalling every other cycle
   task automatic t_drain();
      int k = 0;
      for (int i = 0; i < 60 && k < 5; i++) begin
         @(negedge clk_sys);
         q_ready = i[0];
         if (q_ready && q_valid && q_oe) begin
            cmp_vec("q_data", 128'(WORD0 + 36'(k)), 128'(q_data));
            k++;
         end
      end
      cmp_vec("drained words", 128'(5), 128'(k));
      repeat (3) @(negedge clk_sys);
      cmp_bit("q_valid empty", 1'b0, q_valid);
   endtask : t_drain

   task automatic t_sample_extest();
      @(negedge clk_sys);
      ring_in = {27{4'h6}};
      pat     = {27{4'h9}};
      ir_load(`SBST_IR_SAMPLE);
      i_ctrl.scan(1'b0, 109, {19'h0, 1'b0, pat}, so);
      cmp_vec("sample capture", {19'h0, 1'b1, ring_in}, so);
      chk_mode(1'b1, 1'b0);
      ir_load(`SBST_IR_EXTEST);
      chk_mode(1'b0, 1'b1);
      cmp_vec("ring_out", 128'(pat), 128'(ring_out));
      t_fill();
      i_ctrl.scan(1'b0, 109, {19'h0, 1'b1, pat}, so);
      cmp_vec("extest capture", {19'h0, 1'b0, ring_in}, so);
      chk_mode(1'b1, 1'b1);
      t_drain();
   endtask : t_sample_extest

   // float under sample-z, then reset state presets the control cell
   task automatic t_float_tlr();
      ir_load(`SBST_IR_SAMPLEZ);
      chk_mode(1'b0, 1'b0);
      i_ctrl.scan(1'b0, 109, {19'h0, 1'b0, pat}, so);
      cmp_vec("samplez capture", {19'h0, 1'b1, ring_in}, so);
      ir_load(`SBST_IR_EXTEST);
      chk_mode(1'b0, 1'b1);
      i_ctrl.idle_reset(5);
      chk_mode(1'b1, 1'b0);
      i_ctrl.tick(1'b0, 1'b0, bit_o);
      i_ctrl.scan(1'b0, 32, '0, so);
      cmp_vec("id after reset state", 128'(ID_EXP), so);
   endtask : t_float_tlr

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      reset_n  = 1'b0;
      rd_valid = 1'b0;
      rd_data  = '0;
      q_ready  = 1'b0;
      ring_in  = '0;
      failures = 0;
      compares = 0;
      // odd offset keeps the first reset clocks off the system clock edges; later ticks start on its falling edges
      #1.3;
      i_ctrl.idle_reset(4);
      @(negedge clk_sys);
      reset_n = 1'b1;
      i_ctrl.idle_reset(3);
      i_ctrl.tick(1'b0, 1'b0, bit_o);
      t_reset_id();
      t_bypass();
      // memory clock held steady for the lock time before data is relied on
      #20_000;
      t_sample_extest();
      t_float_tlr();
      results();
   end

   initial begin
      #300_000;
      failures++;
      results();
   end
endmodule : sbst_tap_tb

`default_nettype wire
